// [rtl/cr_remote_frame.sv]
// Module: remote frame request send, accept and reply logic
`timescale 1ns/1ps
// What this block does
// - Scan lowest center first; send remote frame from receive center, ready, request set
// - Successful remote frame send clears that center's transmit request
// - After success, lost arbitration or error, search restarts at lowest center
// - Transmit inhibit is not looked at for remote frame requests
// - On send success clear request, set success flag, irq if enabled
// - Only centers 0 to 13 may originate remote requests
// - No remote requests sent while autobaud detection is active
// - Incoming remote request is zero-length frame; sets pending and receive flags
// - Match ready centers in ascending order with masks; stop at first hit
// - On match load requested byte count and received identifier
// - After storing a remote request raise irq when receive irq enabled
// - Transmit center match sets pending and request; reply when ready, uninhibited, updated
// - After reply set success flag, clear pending and request, irq if enabled
// - Inhibited center still accepts request and updates fields; reply waits
// - No transmit until updated set and inhibit clear; pending cleared afterwards
// - Receive center stores no data, records count and pending, request unchanged
// - Automatic reply: enable with ready, updated, no inhibit, request left clear
// - Gated reply: device waits until software has cleared inhibit and set updated
module cr_remote_frame
    import cr_pkg::*;
#(
    parameter int N = cr_pkg::NUM_CENTERS
) (
    input  wire logic                    mclk,
    input  wire logic                    rst,
    input  wire logic                    autobaudActive,
    input  wire logic                    swCtrlWrite,
    input  wire logic                    swCfgWrite,
    input  wire logic                    swStatusClear,
    input  wire logic [cr_pkg::IDX_W-1:0] swCenter,
    input  wire cr_pkg::cr_ctrl_t        swCtrl,
    input  wire cr_pkg::cr_flags_t       swClearMask,
    input  wire logic [cr_pkg::ID_W-1:0]  swId,
    input  wire logic [cr_pkg::BYC_W-1:0] swByteCount,
    input  wire logic [cr_pkg::ID_W-1:0]  globalMask,
    input  wire logic [cr_pkg::IDX_W-1:0] rdCenter,
    output      logic [cr_pkg::ID_W-1:0]  rdId,
    output      logic [cr_pkg::BYC_W-1:0] rdByteCount,
    output      logic [N-1:0]            stTransmitRequest,
    output      logic [N-1:0]            stRemotePending,
    output      logic [N-1:0]            stTxSuccess,
    output      logic [N-1:0]            stRxSuccess,
    output      logic [N-1:0]            stIrqRequest,
    output      logic                    txStart,
    output      logic [cr_pkg::IDX_W-1:0] txCenter,
    output      logic                    txRemote,
    output      logic                    txExtended,
    output      logic [cr_pkg::ID_W-1:0]  txId,
    output      logic [cr_pkg::BYC_W-1:0] txByteCount,
    input  wire logic                    txDone,
    input  wire logic                    txFail,
    input  wire logic                    rxRemoteValid,
    input  wire logic                    rxExtended,
    input  wire logic [cr_pkg::ID_W-1:0]  rxId,
    input  wire logic [cr_pkg::BYC_W-1:0] rxByteCount,
    output      logic                    rxAccepted,
    output      logic [cr_pkg::IDX_W-1:0] rxCenter
);
    import cr_pkg::*;

    // ==========================================================
    // Elaboration check
    if (N < 2 || N > (1 << IDX_W)) begin : gBadN
        $error("cr_remote_frame: N out of range");
    end

    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(N - 1);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ==========================================================
    // Shared vectors
    logic [N-1:0]      readyVec;
    logic [N-1:0]      txDirVec;
    logic [N-1:0]      txIrqEnVec;
    logic [N-1:0]      rxIrqEnVec;
    logic [N-1:0]      extVec;
    logic [ID_W-1:0]   idArr [N];
    logic [BYC_W-1:0]  bycArr [N];

    cr_state_t         stateReg;
    cr_state_t         stateNext;
    logic [IDX_W-1:0]  activeIdxReg;
    logic [IDX_W-1:0]  activeIdxNext;
    logic              doneHit;
    logic              rxHit;

    cr_scan_if #(.N(N), .IW(IDX_W)) txScan ();
    cr_scan_if #(.N(N), .IW(IDX_W)) rxScan ();

    cr_prio_scan #(.N(N), .IW(IDX_W)) uTxScan (
        .bus (txScan)
    );
    cr_prio_scan #(.N(N), .IW(IDX_W)) uRxScan (
        .bus (rxScan)
    );

    assign doneHit = (stateReg == CR_SEND) && txDone;
    assign rxHit   = rxRemoteValid && rxScan.found;

    // ==========================================================
    // Message centers
    for (genvar i = 0; i < N; i++) begin : gCenter
        cr_ctrl_t          ctrl_reg;
        cr_ctrl_t          ctrl_next;
        cr_flags_t         flag_reg;
        cr_flags_t         flag_next;
        logic [ID_W-1:0]   id_reg;
        logic [ID_W-1:0]   id_next;
        logic [BYC_W-1:0]  byc_reg;
        logic [BYC_W-1:0]  byc_next;
        logic [ID_W-1:0]   effMask;
        logic              sel;
        logic              sendable;

        assign sel = (swCenter == IDX_W'(i));

        // Reply frames gated by inhibit and data-updated; remote requests are not
        always_comb begin
            if (ctrl_reg.txDir) begin
                sendable = !ctrl_reg.transmitInhibit && ctrl_reg.dataUpdated;
            end else begin
                sendable = !autobaudActive;
            end
        end
        // Last center is receive-only
        assign txScan.request[i] = ctrl_reg.centerReady && ctrl_reg.transmitRequest
                                   && sendable && (IDX_W'(i) != LAST_IDX);

        always_comb begin
            effMask = ctrl_reg.idMaskEnable ? globalMask : ID_MASK_ALL;
            if (!ctrl_reg.frameFormatSelect) begin
                effMask = effMask & ID_MASK_STD;
            end
        end
        assign rxScan.request[i] = ctrl_reg.centerReady
                                   && (ctrl_reg.frameFormatSelect == rxExtended)
                                   && (((rxId ^ id_reg) & effMask) == '0);

        always_comb begin
            ctrl_next = ctrl_reg;
            flag_next = flag_reg;
            id_next   = id_reg;
            byc_next  = byc_reg;
            if (swCtrlWrite && sel) begin
                ctrl_next = swCtrl;
            end
            if (swCfgWrite && sel) begin
                id_next  = swId;
                byc_next = swByteCount;
            end
            if (swStatusClear && sel) begin
                flag_next = flag_reg & ~swClearMask;
            end
            // Hardware after software so a hardware update wins over a software write
            if (doneHit && activeIdxReg == IDX_W'(i)) begin
                ctrl_next.transmitRequest = 1'b0;
                if (ctrl_reg.txDir) begin
                    ctrl_next.remoteRequestPending = 1'b0;
                end
                flag_next.transmitSuccessFlag = 1'b1;
                if (ctrl_reg.transmitIrqEnable) begin
                    flag_next.centerIrqRequest = 1'b1;
                end
            end
            if (rxHit && rxScan.index == IDX_W'(i)) begin
                ctrl_next.remoteRequestPending = 1'b1;
                flag_next.receiveSuccessFlag   = 1'b1;
                byc_next = rxByteCount;
                id_next  = rxId;
                if (ctrl_reg.txDir) begin
                    ctrl_next.transmitRequest = 1'b1;
                end
                if (ctrl_reg.receiveIrqEnable) begin
                    flag_next.centerIrqRequest = 1'b1;
                end
            end
        end

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                ctrl_reg <= CTRL_RESET;
                flag_reg <= FLAGS_RESET;
                id_reg   <= ID_RESET;
                byc_reg  <= BYC_RESET;
            end else begin
                ctrl_reg <= ctrl_next;
                flag_reg <= flag_next;
                id_reg   <= id_next;
                byc_reg  <= byc_next;
            end
        end

        assign readyVec[i]          = ctrl_reg.centerReady;
        assign txDirVec[i]          = ctrl_reg.txDir;
        assign txIrqEnVec[i]        = ctrl_reg.transmitIrqEnable;
        assign rxIrqEnVec[i]        = ctrl_reg.receiveIrqEnable;
        assign extVec[i]            = ctrl_reg.frameFormatSelect;
        assign stTransmitRequest[i] = ctrl_reg.transmitRequest;
        assign stRemotePending[i]   = ctrl_reg.remoteRequestPending;
        assign stTxSuccess[i]       = flag_reg.transmitSuccessFlag;
        assign stRxSuccess[i]       = flag_reg.receiveSuccessFlag;
        assign stIrqRequest[i]      = flag_reg.centerIrqRequest;
        assign idArr[i]             = id_reg;
        assign bycArr[i]            = byc_reg;
    end

    // ==========================================================
    // Transmit sequencer
    logic              txStart_next;
    logic              txRemote_next;
    logic              txExt_next;
    logic [ID_W-1:0]   txId_next;
    logic [BYC_W-1:0]  txByc_next;
    logic              txStart_reg;
    logic              txRemote_reg;
    logic              txExt_reg;
    logic [ID_W-1:0]   txId_reg;
    logic [BYC_W-1:0]  txByc_reg;

    always_comb begin
        stateNext     = stateReg;
        activeIdxNext = activeIdxReg;
        txStart_next  = 1'b0;
        txRemote_next = txRemote_reg;
        txExt_next    = txExt_reg;
        txId_next     = txId_reg;
        txByc_next    = txByc_reg;
        case (stateReg)
            CR_IDLE: begin
                if (txScan.found) begin
                    stateNext     = CR_SEND;
                    activeIdxNext = txScan.index;
                    txStart_next  = 1'b1;
                    txRemote_next = !txDirVec[txScan.index];
                    txExt_next    = extVec[txScan.index];
                    txId_next     = idArr[txScan.index];
                    txByc_next    = bycArr[txScan.index];
                end
            end
            CR_SEND: begin
                // Scan always restarts at the lowest center
                if (txDone || txFail) begin
                    stateNext = CR_IDLE;
                end
            end
            default: begin
                stateNext = CR_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stateReg     <= CR_IDLE;
            activeIdxReg <= '0;
            txStart_reg  <= 1'b0;
            txRemote_reg <= 1'b0;
            txExt_reg    <= 1'b0;
            txId_reg     <= ID_RESET;
            txByc_reg    <= BYC_RESET;
        end else begin
            stateReg     <= stateNext;
            activeIdxReg <= activeIdxNext;
            txStart_reg  <= txStart_next;
            txRemote_reg <= txRemote_next;
            txExt_reg    <= txExt_next;
            txId_reg     <= txId_next;
            txByc_reg    <= txByc_next;
        end
    end

    assign txStart     = txStart_reg;
    assign txCenter    = activeIdxReg;
    assign txRemote    = txRemote_reg;
    assign txExtended  = txExt_reg;
    assign txId        = txId_reg;
    assign txByteCount = txByc_reg;

    // ==========================================================
    // Receive report and read-back
    logic              rxAcc_reg;
    logic              rxAcc_next;
    logic [IDX_W-1:0]  rxCtr_reg;
    logic [IDX_W-1:0]  rxCtr_next;
    logic [ID_W-1:0]   rdId_reg;
    logic [ID_W-1:0]   rdId_next;
    logic [BYC_W-1:0]  rdByc_reg;
    logic [BYC_W-1:0]  rdByc_next;

    always_comb begin
        rxAcc_next = rxHit;
        rxCtr_next = rxHit ? rxScan.index : rxCtr_reg;
        rdId_next  = '0;
        rdByc_next = '0;
        // Out-of-range index reads zero
        if (rdCenter <= LAST_IDX) begin
            rdId_next  = idArr[rdCenter];
            rdByc_next = bycArr[rdCenter];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rxAcc_reg <= 1'b0;
            rxCtr_reg <= '0;
            rdId_reg  <= ID_RESET;
            rdByc_reg <= BYC_RESET;
        end else begin
            rxAcc_reg <= rxAcc_next;
            rxCtr_reg <= rxCtr_next;
            rdId_reg  <= rdId_next;
            rdByc_reg <= rdByc_next;
        end
    end

    assign rxAccepted  = rxAcc_reg;
    assign rxCenter    = rxCtr_reg;
    assign rdId        = rdId_reg;
    assign rdByteCount = rdByc_reg;

    // ==========================================================
    // Checks
    tx_pick_a: assert property (
        (stateReg == CR_IDLE && txScan.found)
        |=> (txStart && txCenter == $past(txScan.index)))
        else $error("transmit start missing or wrong center");
    // A request taken by the same center in the same cycle sets it again when that center has txDir set
    done_clear_a: assert property (
        (doneHit && !(rxHit && rxScan.index == activeIdxReg))
        |=> !stTransmitRequest[$past(activeIdxReg)])
        else $error("transmit request not cleared after success");
    rescan_a: assert property (
        (stateReg == CR_SEND && (txDone || txFail)) |=> stateReg == CR_IDLE)
        else $error("no return to scan after end of frame");
    tx_flag_a: assert property (
        (doneHit && txIrqEnVec[activeIdxReg])
        |=> (stTxSuccess[$past(activeIdxReg)] && stIrqRequest[$past(activeIdxReg)]))
        else $error("success flag or irq missing after send");
    last_center_a: assert property (
        txStart |-> txCenter != LAST_IDX)
        else $error("receive-only center started a frame");
    autobaud_block_a: assert property (
        (txStart && txRemote) |-> !$past(autobaudActive))
        else $error("remote request sent during autobaud");
    rx_flags_a: assert property (
        rxHit |=> (stRemotePending[$past(rxScan.index)]
                   && stRxSuccess[$past(rxScan.index)] && rxAccepted))
        else $error("pending or receive flag not set");
    rx_irq_a: assert property (
        (rxHit && rxIrqEnVec[rxScan.index]) |=> stIrqRequest[$past(rxScan.index)])
        else $error("receive irq not raised");
    reply_req_a: assert property (
        (rxHit && txDirVec[rxScan.index]) |=> stTransmitRequest[$past(rxScan.index)])
        else $error("reply request not set");
    tx_ready_a: assert property (
        txStart |-> $past(readyVec[activeIdxNext]))
        else $error("frame started from center not ready");
endmodule

// [rtl/cr_pkg.sv]
// Package: constants and types for the remote frame handler
package cr_pkg;
    // ==========================================================
    // Sizes
    localparam int NUM_CENTERS = 15;
    localparam int IDX_W       = 4;
    localparam int ID_W        = 29;
    localparam int BYC_W       = 4;

    // ==========================================================
    // Identifier masks
    localparam logic [ID_W-1:0] ID_MASK_ALL = 29'h1fffffff;
    localparam logic [ID_W-1:0] ID_MASK_STD = 29'h000007ff;

    // ==========================================================
    // Per-center control written by software in one write
    typedef struct packed {
        logic centerReady;
        logic txDir;
        logic transmitRequest;
        logic transmitInhibit;
        logic dataUpdated;
        logic remoteRequestPending;
        logic transmitIrqEnable;
        logic receiveIrqEnable;
        logic idMaskEnable;
        logic frameFormatSelect;
    } cr_ctrl_t;

    // Per-center sticky status
    typedef struct packed {
        logic transmitSuccessFlag;
        logic receiveSuccessFlag;
        logic centerIrqRequest;
    } cr_flags_t;

    // ==========================================================
    // Reset values
    localparam cr_ctrl_t  CTRL_RESET  = '0;
    localparam cr_flags_t FLAGS_RESET = '0;
    localparam logic [BYC_W-1:0] BYC_RESET = 4'h0;
    localparam logic [ID_W-1:0]  ID_RESET  = 29'h00000000;

    typedef enum logic [0:0] {CR_IDLE, CR_SEND} cr_state_t;
endpackage

// [rtl/cr_scan_if.sv]
// Interface: request vector and lowest-index pick
`timescale 1ns/1ps
interface cr_scan_if #(parameter int N = 15, parameter int IW = 4);
    logic [N-1:0]  request;
    logic          found;
    logic [IW-1:0] index;
    modport scan (input request, output found, output index);
    modport user (output request, input found, input index);
endinterface

// [rtl/cr_prio_scan.sv]
// Module: lowest-numbered request wins
`timescale 1ns/1ps
module cr_prio_scan #(
    parameter int N  = 15,
    parameter int IW = 4
) (
    cr_scan_if.scan bus
);
    // ==========================================================
    // Elaboration check
    if (N < 1 || N > (1 << IW)) begin : gBadN
        $error("cr_prio_scan: N out of range");
    end

    // ==========================================================
    // Priority pick
    // Walking downward leaves the lowest set index last
    always_comb begin
        bus.found = |bus.request;
        bus.index = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (bus.request[i]) begin
                bus.index = IW'(i);
            end
        end
    end
endmodule

// [dv/cr_bus_model.sv]
// Bus model: other nodes answering the block's transmit handshake
`timescale 1ns/1ps
module cr_bus_model (
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic                     txStart,
    input  wire logic [cr_pkg::IDX_W-1:0] txCenter,
    input  wire logic                     txRemote,
    input  wire logic [cr_pkg::BYC_W-1:0] txByteCount,
    input  wire logic [7:0]               delay,
    input  wire logic [3:0]               failFirst,
    output      logic                     txDone,
    output      logic                     txFail,
    output      logic [7:0]               frameCount,
    output      logic [7:0]               startCount,
    output      logic [8:0]               logData [16]
);
    import cr_pkg::*;
    logic       busy;
    logic       failNow;
    logic       doneSeen;
    logic [7:0] cnt;

    // ==========================================================
    // Answer
    // Falling edge, so the block samples settled pulses
    always @(negedge mclk or posedge rst) begin
        if (rst) begin
            busy       <= 1'h0;
            failNow    <= 1'h0;
            doneSeen   <= 1'h0;
            cnt        <= 8'h00;
            txDone     <= 1'h0;
            txFail     <= 1'h0;
            frameCount <= 8'h00;
            startCount <= 8'h00;
        end else begin
            txDone   <= 1'h0;
            txFail   <= 1'h0;
            doneSeen <= 1'h0;
            if (doneSeen) begin
                frameCount <= frameCount + 8'h01;
            end
            if (busy && cnt == 8'h00) begin
                busy     <= 1'h0;
                doneSeen <= 1'h1;
                txDone   <= !failNow;
                txFail   <= failNow;
            end else if (busy) begin
                cnt <= cnt - 8'h01;
            end else if (txStart) begin
                busy                     <= 1'h1;
                cnt                      <= delay;
                // Lost arbitration only where the bench asks for it
                failNow                  <= startCount < {4'h0, failFirst};
                logData[startCount[3:0]] <= {txRemote, txCenter, txByteCount};
                startCount               <= startCount + 8'h01;
            end
        end
    end
endmodule

// [dv/cr_remote_frame_test.sv]
// Testbench: remote frame send, accept and reply sequences
`timescale 1ns/1ps
module cr_remote_frame_test;
    import cr_pkg::*;
    localparam logic [9:0] RDY = 10'h200, TXD = 10'h100, REQ = 10'h080, INH = 10'h040;
    localparam logic [9:0] UPD = 10'h020, PND = 10'h010, TIE = 10'h008, RIE = 10'h004;
    localparam logic [9:0] MSK = 10'h002, EXT = 10'h001;
    logic mclk, rst, autobaudActive, swCtrlWrite, swCfgWrite, swStatusClear;
    logic txStart, txRemote, txExtended, txDone, txFail, rxRemoteValid, rxExtended, rxAccepted;
    logic [IDX_W-1:0] swCenter, rdCenter, txCenter, rxCenter;
    logic [BYC_W-1:0] swByteCount, rdByteCount, txByteCount, rxByteCount;
    logic [ID_W-1:0]  swId, globalMask, rdId, txId, rxId;
    logic [14:0]      stTransmitRequest, stRemotePending, stTxSuccess, stRxSuccess, stIrqRequest;
    cr_ctrl_t         swCtrl;
    cr_flags_t        swClearMask;
    logic [7:0]       delay, frameCount, startCount;
    logic [3:0]       failFirst;
    logic [8:0]       logData [16];
    int               fails, comparisons, cycles;

    cr_remote_frame u_cr_remote_frame (.mclk, .rst, .autobaudActive, .swCtrlWrite, .swCfgWrite,
        .swStatusClear, .swCenter, .swCtrl, .swClearMask, .swId, .swByteCount, .globalMask,
        .rdCenter, .rdId, .rdByteCount, .stTransmitRequest, .stRemotePending, .stTxSuccess,
        .stRxSuccess, .stIrqRequest, .txStart, .txCenter, .txRemote, .txExtended, .txId,
        .txByteCount, .txDone, .txFail, .rxRemoteValid, .rxExtended, .rxId, .rxByteCount,
        .rxAccepted, .rxCenter);
    cr_bus_model u_cr_bus_model (.mclk, .rst, .txStart, .txCenter, .txRemote, .txByteCount,
        .delay, .failFirst, .txDone, .txFail, .frameCount, .startCount, .logData);

    // ==========================================================
    // Clock and hang guard
    initial begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            test_done();
        end
    end

    // ==========================================================
    // Access tasks
    task automatic test_done();
        if (fails == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic wrCtrl(input logic [3:0] c, input logic [9:0] v);
        @(negedge mclk);
        swCenter = c;
        swCtrl = cr_ctrl_t'(v);
        swCtrlWrite = 1'h1;
        @(negedge mclk);
        swCtrlWrite = 1'h0;
    endtask
    task automatic wrCfg(input logic [3:0] c, input logic [28:0] id, input logic [3:0] n);
        @(negedge mclk);
        swCenter = c;
        swId = id;
        swByteCount = n;
        swCfgWrite = 1'h1;
        @(negedge mclk);
        swCfgWrite = 1'h0;
    endtask
    // Expected center f means no center may take the frame
    task automatic rxFrame(input logic x, input logic [28:0] id, input logic [3:0] n,
                           input logic [3:0] e);
        @(negedge mclk);
        rxExtended = x;
        rxId = id;
        rxByteCount = n;
        rxRemoteValid = 1'h1;
        @(negedge mclk);
        rxRemoteValid = 1'h0;
        rxId = ~id;
        rxByteCount = ~n;
        chk(rxAccepted, e != 4'hf);
        if (e != 4'hf) chk(rxCenter, e);
    endtask
    task automatic rdBack(input logic [3:0] c, input logic [28:0] id, input logic [3:0] n);
        @(negedge mclk);
        rdCenter = c;
        @(negedge mclk);
        chk(rdId, id);
        chk(rdByteCount, n);
    endtask
    task automatic waitFrames(input logic [7:0] n);
        int i;
        for (i = 0; i < 300 && frameCount < n; i++) @(negedge mclk);
        chk(frameCount, n);
    endtask

    // ==========================================================
    // Sequences
    initial begin
        {autobaudActive, swCtrlWrite, swCfgWrite, swStatusClear, rxRemoteValid} = 5'h10;
        {swCenter, rdCenter, swId, swByteCount, rxExtended, rxId, rxByteCount} = '0;
        swCtrl = CTRL_RESET;
        swClearMask = FLAGS_RESET;
        globalMask = 29'h1fffffff;
        delay = 8'h03;
        failFirst = 4'h1;
        rst = 1'h1;
        idle(10);
        rst = 1'h0;
        wrCtrl(4'h2, 10'h000);
        wrCfg(4'h2, 29'h120, 4'h0);
        wrCtrl(4'h2, RDY | REQ | INH | TIE);
        wrCfg(4'h5, 29'h150, 4'h0);
        wrCtrl(4'h5, RDY | REQ);
        wrCfg(4'he, 29'h7f0, 4'h0);
        wrCtrl(4'he, RDY | REQ);
        idle(10);
        chk(startCount, 8'h00);
        autobaudActive = 1'h0;
        waitFrames(8'h03);
        chk(logData[0], 9'h120);
        chk(logData[1], 9'h120);
        chk(logData[2], 9'h150);
        chk({txExtended, txId}, {1'h0, 29'h150});
        idle(10);
        chk(startCount, 8'h03);
        chk(stTransmitRequest, 15'h4000);
        chk(stTxSuccess, 15'h0024);
        chk(stIrqRequest, 15'h0004);
        // Slow answers from here on
        delay = 8'h0c;
        wrCtrl(4'h3, TXD | INH);
        wrCfg(4'h3, 29'h130, 4'h2);
        wrCtrl(4'h3, TXD | RDY | UPD | TIE | RIE);
        idle(6);
        chk(startCount, 8'h03);
        rxFrame(1'h0, 29'h130, 4'h6, 4'h3);
        chk({stTransmitRequest[3], stRemotePending[3]}, 2'h3);
        chk({stRxSuccess[3], stIrqRequest[3]}, 2'h3);
        waitFrames(8'h04);
        chk(logData[3], 9'h036);
        chk({txExtended, txId}, {1'h0, 29'h130});
        chk({stTransmitRequest[3], stRemotePending[3], stTxSuccess[3]}, 3'h1);
        wrCtrl(4'h4, TXD | INH | EXT);
        wrCfg(4'h4, 29'h1abcdef0, 4'h1);
        wrCtrl(4'h4, TXD | RDY | UPD | INH | EXT);
        rxFrame(1'h1, 29'h1abcdef0, 4'h8, 4'h4);
        idle(20);
        chk(startCount, 8'h04);
        chk({stTransmitRequest[4], stRemotePending[4]}, 2'h3);
        rdBack(4'h4, 29'h1abcdef0, 4'h8);
        wrCtrl(4'h4, TXD | RDY | REQ | PND | INH | EXT);
        wrCtrl(4'h4, TXD | RDY | REQ | PND | EXT);
        idle(8);
        chk(startCount, 8'h04);
        wrCtrl(4'h4, TXD | RDY | REQ | PND | UPD | EXT);
        waitFrames(8'h05);
        chk(logData[4], 9'h048);
        chk({txExtended, txId}, {1'h1, 29'h1abcdef0});
        chk({stTransmitRequest[4], stRemotePending[4]}, 2'h0);
        wrCfg(4'h6, 29'h160, 4'h0);
        wrCtrl(4'h6, RDY);
        wrCfg(4'h7, 29'h160, 4'h0);
        wrCtrl(4'h7, RDY | RIE);
        wrCtrl(4'h8, RDY | MSK);
        rxFrame(1'h0, 29'h171, 4'h3, 4'hf);
        globalMask = 29'h0;
        rxFrame(1'h0, 29'h160, 4'h5, 4'h6);
        chk({stRxSuccess[6], stRemotePending[7:6], stTransmitRequest[6]}, 4'ha);
        chk(stIrqRequest[7:6], 2'h0);
        rdBack(4'h6, 29'h160, 4'h5);
        rxFrame(1'h0, 29'h171, 4'h3, 4'h8);
        rdBack(4'h8, 29'h171, 4'h3);
        wrCtrl(4'h6, RDY);
        chk(stRemotePending[6], 1'h0);
        @(negedge mclk);
        swCenter = 4'h2;
        swClearMask = '1;
        swStatusClear = 1'h1;
        @(negedge mclk);
        swStatusClear = 1'h0;
        chk({stTxSuccess[2], stIrqRequest[2]}, 2'h0);
        idle(10);
        chk(startCount, 8'h05);
        test_done();
    end
endmodule
